//--- design/crosspoint_serial_config.v
// Purpose: Serial configuration logic of an 8x4 crosspoint switch
// Assumes: Serial pins sampled by core_clk, far faster than serial clock
// Notes: Serial clock edges are found from synchronised samples
`timescale 1ns/100ps
`default_nettype none
`include "xpt_cfg_defines.vh"
module crosspoint_serial_config #(
  parameter OUTPUTS = `NUM_OUTPUTS,
  parameter FRAME = `FRAME_BITS
) (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  input wire cfg,
  input wire mode,
  input wire rst_pin,
  input wire all_outputs_input0,
  output reg sdo,
  output reg [3*OUTPUTS-1:0] out_sel,
  output reg [OUTPUTS-1:0] out_off
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  wire [6:0] s;
  pin_sync #(.WIDTH(7)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({all_outputs_input0, rst_pin, mode, cfg, sdi, cs_n, sclk}),
    .sync_out(s)
  );
  wire sclk_s = s[0];
  wire cs_n_s = s[1];
  wire sdi_s = s[2];
  wire cfg_s = s[3];
  wire mode_s = s[4];
  wire rst_s = s[5];
  wire bcast_s = s[6];
  reg sclk_d;
  reg cfg_d;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cfg_rise = cfg_s & ~cfg_d;
  ////////////////////////////////////////////////////////////////////////
  // Receive sequencing
  localparam ST_IDLE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_RECV = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [FRAME-1:0] shadow;
  reg [`ADDR_WORD_BITS-1:0] addr_word;
  reg fresh;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!cs_n_s) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cs_n_s) begin
          next_state = ST_IDLE;
        end else if (sclk_rise) begin
          next_state = ST_RECV;
        end
      end
      ST_RECV: begin
        if (cs_n_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  wire take_bit = (state == ST_RECV) && !cs_n_s && sclk_fall;
  // Arming rise already presents the oldest bit to a chained device
  wire push_out = (state == ST_WAIT || state == ST_RECV) && !cs_n_s &&
    sclk_rise && !mode_s;
  ////////////////////////////////////////////////////////////////////////
  // Shadow bank next values
  reg [FRAME-1:0] next_shadow;
  reg [`ADDR_WORD_BITS-1:0] next_addr_word;
  reg next_sdo;
  always @* begin
    next_shadow = shadow;
    next_addr_word = addr_word;
    next_sdo = sdo;
    if (take_bit) begin
      if (mode_s) begin
        next_addr_word = {sdi_s, addr_word[`ADDR_WORD_BITS-1:1]};
      end else begin
        next_shadow = {sdi_s, shadow[FRAME-1:1]};
      end
    end
    if (push_out) begin
      next_sdo = shadow[0];
    end
  end
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      sclk_d <= 1'b0;
      cfg_d <= 1'b0;
      shadow <= {FRAME{1'b0}};
      addr_word <= {`ADDR_WORD_BITS{1'b0}};
      sdo <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      sclk_d <= sclk_s;
      cfg_d <= cfg_s;
      shadow <= next_shadow;
      addr_word <= next_addr_word;
      sdo <= next_sdo;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Fresh-data tracking
  // A bit taken in the same cycle as a commit keeps the flag set
  reg fresh_mode;
  reg next_fresh;
  reg next_fresh_mode;
  always @* begin
    next_fresh = fresh;
    next_fresh_mode = fresh_mode;
    if (rst_s) begin
      next_fresh = 1'b0;
    end else if (take_bit) begin
      next_fresh = 1'b1;
      next_fresh_mode = mode_s;
    end else if (cfg_rise) begin
      next_fresh = 1'b0;
    end
  end
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fresh <= 1'b0;
      fresh_mode <= 1'b0;
    end else if (clk_en) begin
      fresh <= next_fresh;
      fresh_mode <= next_fresh_mode;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Active registers
  wire [1:0] a_out = addr_word[`ADDR_OUT_LSB+1:`ADDR_OUT_LSB];
  wire [2:0] a_sel = addr_word[`ADDR_SEL_LSB+2:`ADDR_SEL_LSB];
  wire a_off = addr_word[`ADDR_OFF_BIT];
  wire [3*OUTPUTS-1:0] next_out_sel;
  wire [OUTPUTS-1:0] next_out_off;
  genvar g;
  generate
    for (g = 0; g < OUTPUTS; g = g + 1) begin : g_out
      wire [2:0] frame_sel = shadow[`FIELD_BITS*g+2:`FIELD_BITS*g];
      wire frame_off = shadow[`FIELD_BITS*g+`FIELD_OFF_BIT];
      wire named = (a_out == g);
      reg [2:0] sel_n;
      reg off_n;
      // Reset outranks broadcast, both outrank a commit
      always @* begin
        sel_n = out_sel[3*g+2:3*g];
        off_n = out_off[g];
        if (rst_s) begin
          sel_n = `RESET_SEL;
          off_n = `RESET_OFF;
        end else if (bcast_s) begin
          sel_n = `BCAST_SEL;
          off_n = 1'b0;
        end else if (cfg_rise && fresh) begin
          if (!fresh_mode) begin
            sel_n = frame_sel;
            off_n = frame_off;
          end else if (named) begin
            sel_n = a_sel;
            off_n = a_off;
          end
        end
      end
      assign next_out_sel[3*g+2:3*g] = sel_n;
      assign next_out_off[g] = off_n;
    end
  endgenerate
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_sel <= {OUTPUTS{`RESET_SEL}};
      out_off <= {OUTPUTS{`RESET_OFF}};
    end else if (clk_en) begin
      out_sel <= next_out_sel;
      out_off <= next_out_off;
    end
  end
endmodule
`default_nettype wire

//--- design/xpt_cfg_defines.vh
// Purpose: Constants for the crosspoint serial configuration block
// Assumes: Included by bare name from design files
// Notes: Field positions count from the first bit shifted in
`ifndef XPT_CFG_DEFINES_VH
`define XPT_CFG_DEFINES_VH
`define FRAME_BITS 16
`define FIELD_BITS 4
`define NUM_OUTPUTS 4
`define SEL_BITS 3
`define ADDR_WORD_BITS 6
`define ADDR_OUT_LSB 0
`define ADDR_SEL_LSB 2
`define ADDR_OFF_BIT 5
`define FIELD_OFF_BIT 3
`define RESET_SEL 3'h0
`define RESET_OFF 1'b1
`define BCAST_SEL 3'h0
`endif

//--- design/pin_sync.v
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- sim/xpt_cfg_asserts.sv
// Purpose: Pin-level checks of the crosspoint config block
// Assumes: Outputs hold still while clk_en is low
// Notes: Bound to the design top
`timescale 1ns/100ps
`default_nettype none
module xpt_asserts (
  input wire core_clk,
  input wire resetn,
  input wire sclk,
  input wire cs_n,
  input wire cfg,
  input wire mode,
  input wire rst_pin,
  input wire all_outputs_input0,
  input wire sdo,
  input wire [11:0] out_sel,
  input wire [3:0] out_off
);
  wire quiet = !cfg && !rst_pin && !all_outputs_input0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rst_off: assert property (rst_pin[*5] |->
    out_off == 4'hF && out_sel == 12'h000) else $error("reset pin");
  a_rst_soon: assert property ($rose(rst_pin) |->
    ##[2:5] out_off == 4'hF) else $error("reset late");
  a_rst_wins: assert property ((rst_pin && all_outputs_input0)[*5]
    |-> out_off == 4'hF) else $error("priority");
  a_bcast_on: assert property ((all_outputs_input0 && !rst_pin)[*6]
    |-> out_off == 4'h0 && out_sel == 12'h000) else $error("broadcast");
  a_hold_idle: assert property (quiet[*6] |=>
    $stable(out_sel) && $stable(out_off)) else $error("spurious");
  a_sdo_rise: assert property ((!sclk && !rst_pin)[*6] |=>
    $stable(sdo)) else $error("sdo moved");
  a_sdo_cs: assert property ((cs_n && !rst_pin)[*6] |=>
    $stable(sdo)) else $error("sdo while idle");
  a_sdo_addr: assert property ((mode && !rst_pin)[*6] |=>
    $stable(sdo)) else $error("sdo in word mode");
endmodule
bind crosspoint_serial_config xpt_asserts chk_u (.*);
`default_nettype wire

//--- sim/serial_ctl.sv
// Purpose: Controller model for the serial config pins
// Assumes: Serial clock half period is 4 core_clk
// Notes: Serial clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module serial_ctl (
  input wire logic core_clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  output logic cfg,
  output logic mode
);
  logic [15:0] q;
  initial begin
    {sclk, sdi, cfg, mode} = 4'h0;
    cs_n = 1'b1;
  end
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task load(input logic [15:0] d, input int n, input logic m, input logic c,
    input logic tw);
    mode = m;
    cs_n = c;
    cfg = tw & c;
    tick(4);
    sclk = 1'b1;
    for (int i = 0; i < n; i++) begin
      sdi = d[i];
      tick(4);
      q[i] = sdo;
      sclk = 1'b0;
      tick(4);
      if (i < n - 1) sclk = 1'b1;
    end
    cs_n = 1'b1;
    cfg = tw;
    sdi = ~sdi;
    tick(4);
    sclk = 1'b1;
    tick(4);
    sclk = 1'b0;
    tick(4);
    if (!tw) begin
      cfg = 1'b1;
      tick(4);
      cfg = 1'b0;
    end
    tick(8);
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: Self-checking bench for the crosspoint config block
// Assumes: clk_en high except during the freeze test
// Notes: Rows cover both formats, then pin overrides
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic rst_pin = 1'b0;
  logic bcast = 1'b0;
  logic clk_en = 1'b1;
  wire sclk, cs_n, sdi, cfg, mode, sdo;
  wire [11:0] out_sel;
  wire [3:0] out_off;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [15:0] r_d[4] = '{16'h07A5, 16'h000E, 16'h0011, 16'hFFFF};
  logic r_m[4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  logic [15:0] r_e[4] = '{16'h1D52, 16'h0D52, 16'h0E50, 16'hFFFF};
  always #12.5 core_clk = ~core_clk;
  serial_ctl ctl_u (.core_clk(core_clk), .sdo(sdo), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .cfg(cfg), .mode(mode));
  crosspoint_serial_config dut_u (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .cfg(cfg),
    .mode(mode), .rst_pin(rst_pin), .all_outputs_input0(bcast),
    .sdo(sdo), .out_sel(out_sel), .out_off(out_off));
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    ctl_u.tick(2);
    chk({out_sel, out_off}, 16'h000F);
    resetn = 1'b1;
    $display("reset test done");
    ctl_u.tick(3);
    for (int i = 0; i < 4; i++) begin
      ctl_u.load(r_d[i], r_m[i] ? 6 : 16, r_m[i], 1'b0, 1'b0);
      chk({out_sel, out_off}, r_e[i]);
      $display("row %0d done", i);
    end
    clk_en = 1'b0;
    ctl_u.load(16'h0000, 16, 1'b0, 1'b0, 1'b0);
    chk({out_sel, out_off}, 16'hFFFF);
    clk_en = 1'b1;
    $display("freeze test done");
    ctl_u.load(16'h0000, 16, 1'b0, 1'b1, 1'b0);
    chk({out_sel, out_off}, 16'hFFFF);
    $display("select test done");
    ctl_u.load(16'h0000, 16, 1'b0, 1'b0, 1'b0);
    chk(ctl_u.q, 16'hFFFF);
    chk({out_sel, out_off}, 16'h0000);
    ctl_u.load(16'h07A5, 16, 1'b0, 1'b0, 1'b1);
    chk({out_sel, out_off}, 16'h1D52);
    $display("three-wire test done");
    rst_pin = 1'b1;
    bcast = 1'b1;
    ctl_u.tick(6);
    chk({out_sel, out_off}, 16'h000F);
    rst_pin = 1'b0;
    ctl_u.tick(6);
    chk({out_sel, out_off}, 16'h0000);
    $display("override tests done");
    print_verdict;
  end
endmodule
`default_nettype wire
